// >>> design/dsm_pkg.sv
package dsm_pkg;

   // Command bus widths
   localparam int ADDR_W     = 13;                      // Row / mode address bits
   localparam int BA_W       = 2;                       // Bank select bits
   localparam int NBANK      = 4;                       // Internal banks
   localparam int COL_W      = 10;                      // Column address bits
   localparam int AP_BIT     = 10;                      // Auto precharge / all-banks bit

   // Data path widths
   localparam int DQ_W       = 16;                      // Data word width
   localparam int LANES      = DQ_W / 8;                // Byte lanes, one strobe and mask each

   // Stored array: low row and column bits only, higher bits alias
   localparam int ROW_IDX_W  = 2;                       // Row bits kept in storage
   localparam int COL_IDX_W  = 3;                       // Column bits kept in storage
   localparam int MEM_ADDR_W = BA_W + ROW_IDX_W + COL_IDX_W;
   localparam int MEM_WORDS  = 1 << MEM_ADDR_W;

   // Mode register field layout
   localparam int MR_BL_LSB      = 0;                   // Burst length field, 3 bits
   localparam int MR_BT_BIT      = 3;                   // Burst type, 1 = interleaved
   localparam int MR_CL_LSB      = 4;                   // Latency field, 3 bits
   localparam int MR_OP_LSB      = 7;                   // Operating mode field, 6 bits
   localparam int MR_DLL_RST_BIT = 8;                   // Self-clearing DLL reset request
   localparam int EMR_DLL_DIS_BIT = 0;                  // Extended word: 1 disables the DLL

   // Field encodings
   localparam logic [2:0] BL_2      = 3'h1;
   localparam logic [2:0] BL_4      = 3'h2;
   localparam logic [2:0] BL_8      = 3'h3;
   localparam logic [2:0] CL_2      = 3'h2;
   localparam logic [2:0] CL_2P5    = 3'h6;
   localparam logic [5:0] OP_NORMAL = 6'h00;
   localparam logic [5:0] OP_DLLRST = 6'h02;

   // Reset values
   localparam logic [ADDR_W-1:0] MR_RESET  = 13'h0000;
   localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;

   // Timing counts, in link clock cycles
   localparam int               DLL_CYCLES = 200;       // DLL reset to first read
   localparam int               DLL_CNT_W  = 8;
   localparam logic [1:0]       RD_WAIT    = 2'h1;      // Extra wait before first read pair

   // Command codes as {ras_n, cas_n, we_n} with select low
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_RD  = 3'h5;

   // Bank address of each mode word
   localparam logic [BA_W-1:0] BA_MR  = 2'h0;
   localparam logic [BA_W-1:0] BA_EMR = 2'h1;

   // Burst engine activity
   typedef enum logic [1:0] {
      DSM_B_IDLE  = 2'h0,
      DSM_B_READ  = 2'h1,
      DSM_B_TAIL  = 2'h3,
      DSM_B_WRITE = 2'h2
   } dsm_burst_t;

   // Power-up progress, Gray coded along the expected order
   typedef enum logic [3:0] {
      DSM_I_CKE   = 4'h0,
      DSM_I_PALL  = 4'h1,
      DSM_I_EMR   = 4'h3,
      DSM_I_DLL   = 4'h2,
      DSM_I_PALL2 = 4'h6,
      DSM_I_REF1  = 4'h7,
      DSM_I_REF2  = 4'h5,
      DSM_I_MR    = 4'h4,
      DSM_I_READY = 4'hc
   } dsm_init_t;

   // Command pins as sampled at the rising link edge
   typedef struct packed {
      logic              cke;
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BA_W-1:0]   ba;
      logic [ADDR_W-1:0] addr;
   } dsm_cmd_t;

   // One clock of double-rate data: first and second half
   typedef struct packed {
      logic [DQ_W-1:0]  dq_rise;
      logic [DQ_W-1:0]  dq_fall;
      logic [LANES-1:0] dqs_rise;
      logic [LANES-1:0] dqs_fall;
   } dsm_ddr_t;

endpackage

// >>> design/dsm_core.sv
`timescale 1ns/1ps
module dsm_core
   import dsm_pkg::*;
(
   // System side
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // Link side, clocked by the controller's clock
   input  wire logic             ck_i,
   input  wire dsm_cmd_t         cmd_i,
   input  wire dsm_ddr_t         wr_i,
   input  wire logic [LANES-1:0] dm_rise_i,
   input  wire logic [LANES-1:0] dm_fall_i,
   // Read data and strobes toward the pins
   output logic                  dq_oe_o,
   output logic                  dqs_oe_o,
   output dsm_ddr_t              rd_o,
   // Mode word as seen by the link
   output logic [ADDR_W-1:0]     mode_o,
   // Status in the system domain
   output logic                  ready_o,
   output logic                  dll_locked_o
);

   // Link domain state
   typedef struct packed {
      logic [ADDR_W-1:0]                 mode;
      logic [ADDR_W-1:0]                 emode;
      dsm_init_t                         init;
      logic [DLL_CNT_W-1:0]              dll_cnt;
      logic                              dll_done;
      logic [NBANK-1:0]                  open;
      logic [NBANK-1:0][ADDR_W-1:0]      row;
      dsm_burst_t                        kind;
      logic [BA_W-1:0]                   bbank;
      logic [COL_W-1:0]                  bcol;
      logic                              bap;
      logic [1:0]                        bwait;
      logic [3:0]                        bidx;
      logic [DQ_W-1:0]                   hold;
      logic                              dq_oe;
      logic                              dqs_oe;
      dsm_ddr_t                          rd;
      logic                              ready;
      logic [MEM_WORDS-1:0][DQ_W-1:0]    mem;
   } dsm_link_t;

   // System domain state: two-flop synchronisers only
   typedef struct packed {
      logic ready_s1;
      logic ready_s2;
      logic lock_s1;
      logic lock_s2;
   } dsm_sys_t;

   dsm_link_t lk_ff;     // Link registers
   dsm_link_t nxt_lk;    // Next link value
   dsm_sys_t  sy_ff;     // System registers
   dsm_sys_t  nxt_sy;    // Next system value

   // Burst length in words; reserved codes fall back to two
   function automatic logic [3:0] burst_len(input logic [2:0] code);
      case (code)
         BL_4:    burst_len = 4'h4;
         BL_8:    burst_len = 4'h8;
         default: burst_len = 4'h2;
      endcase
   endfunction

   // Column of word idx, wrapping inside the aligned block
   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                   input logic [3:0]       idx,
                                                   input logic [3:0]       len,
                                                   input logic             inter);
      logic [COL_W-1:0] mask;
      logic [COL_W-1:0] off;
      mask = {6'h00, len - 4'h1};
      off  = inter ? (start ^ {6'h00, idx}) : (start + {6'h00, idx});
      burst_col = (start & ~mask) | (off & mask);
   endfunction

   // Storage index; upper row and column bits alias onto the kept ones
   function automatic logic [MEM_ADDR_W-1:0] mem_idx(input logic [BA_W-1:0]   bank,
                                                     input logic [ADDR_W-1:0] row,
                                                     input logic [COL_W-1:0]  col);
      mem_idx = {bank, row[ROW_IDX_W-1:0], col[COL_IDX_W-1:0]};
   endfunction

   // Link next state: burst engine, command decode, init tracking
   always_comb begin
      logic [3:0]            len;
      logic                  inter;
      logic                  half;
      logic [MEM_ADDR_W-1:0] a0;
      logic [MEM_ADDR_W-1:0] a1;
      logic [DQ_W-1:0]       w0;
      logic [DQ_W-1:0]       w1;
      logic                  last;
      logic                  cmd_ok;
      logic [2:0]            op;
      nxt_lk = lk_ff;
      len    = burst_len(lk_ff.mode[MR_BL_LSB +: 3]);
      inter  = lk_ff.mode[MR_BT_BIT];
      half   = (lk_ff.mode[MR_CL_LSB +: 3] == CL_2P5);
      a0     = mem_idx(lk_ff.bbank, lk_ff.row[lk_ff.bbank],
                       burst_col(lk_ff.bcol, lk_ff.bidx, len, inter));
      a1     = mem_idx(lk_ff.bbank, lk_ff.row[lk_ff.bbank],
                       burst_col(lk_ff.bcol, lk_ff.bidx + 4'h1, len, inter));
      w0     = lk_ff.mem[a0];
      w1     = lk_ff.mem[a1];
      last   = (lk_ff.bidx + 4'h2 >= len);
      cmd_ok = cmd_i.cke && !cmd_i.cs_n;
      op     = {cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};

      // The DLL reset request is a pulse, never a held bit
      nxt_lk.mode[MR_DLL_RST_BIT] = 1'b0;

      // Pins idle unless read data or the half-clock-latency strobe preamble goes out this cycle
      nxt_lk.dq_oe  = 1'b0;
      nxt_lk.dqs_oe = 1'b0;
      nxt_lk.rd     = '0;

      // DLL settle counter, restarted by each DLL reset load
      if (lk_ff.dll_cnt != DLL_CYCLES[DLL_CNT_W-1:0]) begin
         nxt_lk.dll_cnt = lk_ff.dll_cnt + 8'h01;
      end
      nxt_lk.dll_done = (lk_ff.dll_cnt == DLL_CYCLES[DLL_CNT_W-1:0]);

      // Burst engine, one pair of words per clock
      case (lk_ff.kind)
         DSM_B_READ: begin
            if (lk_ff.bwait != 2'h0) begin
               nxt_lk.bwait = lk_ff.bwait - 2'h1;
               // Half-clock latency: strobe and data start mid-cycle
               if (lk_ff.bwait == 2'h1 && half) begin
                  nxt_lk.dqs_oe = 1'b1;
               end
            end else begin
               nxt_lk.dq_oe  = 1'b1;
               nxt_lk.dqs_oe = 1'b1;
               // Strobe high in first half, low in second: edges on data edges
               nxt_lk.rd.dqs_rise = '1;
               nxt_lk.rd.dqs_fall = '0;
               if (half) begin
                  nxt_lk.rd.dq_rise = lk_ff.hold;
                  nxt_lk.rd.dq_fall = w0;
                  nxt_lk.hold       = w1;
               end else begin
                  nxt_lk.rd.dq_rise = w0;
                  nxt_lk.rd.dq_fall = w1;
               end
               nxt_lk.bidx = lk_ff.bidx + 4'h2;
               if (last) begin
                  if (half) begin
                     nxt_lk.kind = DSM_B_TAIL;
                  end else begin
                     nxt_lk.kind = DSM_B_IDLE;
                     if (lk_ff.bap) begin
                        nxt_lk.open[lk_ff.bbank] = 1'b0;
                     end
                  end
               end
            end
         end
         DSM_B_TAIL: begin
            // Last word of a half-clock-latency read, driven in both halves
            nxt_lk.dq_oe       = 1'b1;
            nxt_lk.dqs_oe      = 1'b1;
            nxt_lk.rd.dqs_rise = '1;
            nxt_lk.rd.dq_rise  = lk_ff.hold;
            nxt_lk.rd.dq_fall  = lk_ff.hold;
            nxt_lk.kind        = DSM_B_IDLE;
            if (lk_ff.bap) begin
               nxt_lk.open[lk_ff.bbank] = 1'b0;
            end
         end
         DSM_B_WRITE: begin
            // Each lane stored per strobe edge unless its mask is high
            for (int b = 0; b < LANES; b++) begin
               if (wr_i.dqs_rise[b] && !dm_rise_i[b]) begin
                  nxt_lk.mem[a0][b*8 +: 8] = wr_i.dq_rise[b*8 +: 8];
               end
               if (!wr_i.dqs_fall[b] && !dm_fall_i[b]) begin
                  nxt_lk.mem[a1][b*8 +: 8] = wr_i.dq_fall[b*8 +: 8];
               end
            end
            nxt_lk.bidx = lk_ff.bidx + 4'h2;
            if (last) begin
               nxt_lk.kind = DSM_B_IDLE;
               if (lk_ff.bap) begin
                  nxt_lk.open[lk_ff.bbank] = 1'b0;
               end
            end
         end
         default: begin
            nxt_lk.kind = DSM_B_IDLE;
         end
      endcase

      // Command decode; bank state is per bank so others run alongside
      if (cmd_ok) begin
         case (op)
            CMD_ACT: begin
               nxt_lk.open[cmd_i.ba] = 1'b1;
               nxt_lk.row[cmd_i.ba]  = cmd_i.addr;
            end
            CMD_RD, CMD_WR: begin
               // A closed bank has no row to access: command ignored
               if (lk_ff.open[cmd_i.ba]) begin
                  nxt_lk.kind  = (op == CMD_RD) ? DSM_B_READ : DSM_B_WRITE;
                  nxt_lk.bbank = cmd_i.ba;
                  nxt_lk.bcol  = cmd_i.addr[COL_W-1:0];
                  nxt_lk.bap   = cmd_i.addr[AP_BIT];
                  nxt_lk.bidx  = 4'h0;
                  nxt_lk.bwait = (op == CMD_RD) ? RD_WAIT : 2'h0;
               end
            end
            CMD_PRE: begin
               if (cmd_i.addr[AP_BIT]) begin
                  nxt_lk.open = '0;
               end else begin
                  nxt_lk.open[cmd_i.ba] = 1'b0;
               end
            end
            CMD_MRS: begin
               // Mode words change and a DLL reset load restarts the settle counter; the array is untouched
               if (cmd_i.ba == BA_MR) begin
                  nxt_lk.mode = cmd_i.addr;
                  if (cmd_i.addr[MR_OP_LSB +: 6] == OP_DLLRST) begin
                     nxt_lk.dll_cnt  = '0;
                     nxt_lk.dll_done = 1'b0;
                  end
               end else if (cmd_i.ba == BA_EMR) begin
                  nxt_lk.emode = cmd_i.addr;
               end
            end
            default: begin
               nxt_lk.open = nxt_lk.open;
            end
         endcase
      end

      // Power-up progress as seen from the command stream
      case (lk_ff.init)
         DSM_I_CKE: begin
            if (cmd_i.cke) nxt_lk.init = DSM_I_PALL;
         end
         DSM_I_PALL: begin
            if (cmd_ok && op == CMD_PRE && cmd_i.addr[AP_BIT]) nxt_lk.init = DSM_I_EMR;
         end
         DSM_I_EMR: begin
            if (cmd_ok && op == CMD_MRS && cmd_i.ba == BA_EMR
                && !cmd_i.addr[EMR_DLL_DIS_BIT]) nxt_lk.init = DSM_I_DLL;
         end
         DSM_I_DLL: begin
            if (cmd_ok && op == CMD_MRS && cmd_i.ba == BA_MR
                && cmd_i.addr[MR_OP_LSB +: 6] == OP_DLLRST) nxt_lk.init = DSM_I_PALL2;
         end
         DSM_I_PALL2: begin
            if (cmd_ok && op == CMD_PRE && cmd_i.addr[AP_BIT]) nxt_lk.init = DSM_I_REF1;
         end
         DSM_I_REF1: begin
            if (cmd_ok && op == CMD_REF) nxt_lk.init = DSM_I_REF2;
         end
         DSM_I_REF2: begin
            if (cmd_ok && op == CMD_REF) nxt_lk.init = DSM_I_MR;
         end
         DSM_I_MR: begin
            if (cmd_ok && op == CMD_MRS && cmd_i.ba == BA_MR
                && cmd_i.addr[MR_OP_LSB +: 6] == OP_NORMAL) nxt_lk.init = DSM_I_READY;
         end
         DSM_I_READY: begin
            nxt_lk.init = DSM_I_READY;
         end
         default: begin
            nxt_lk.init = DSM_I_CKE;
         end
      endcase
      nxt_lk.ready = (nxt_lk.init == DSM_I_READY);

      // With clock enable low nothing is driven onto the pins
      if (!cmd_i.cke) begin
         nxt_lk.dq_oe  = 1'b0;
         nxt_lk.dqs_oe = 1'b0;
         nxt_lk.rd     = '0;
      end
   end

   // Link registers; the link clock may stop, reset does not need it to run
   always_ff @(posedge ck_i or posedge rst_i) begin
      if (rst_i) begin
         lk_ff       <= '0;
         lk_ff.mode  <= MR_RESET;
         lk_ff.emode <= EMR_RESET;
         lk_ff.init  <= DSM_I_CKE;
         lk_ff.kind  <= DSM_B_IDLE;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // System next state: status levels cross through two flops
   always_comb begin
      nxt_sy          = sy_ff;
      nxt_sy.ready_s1 = lk_ff.ready;
      nxt_sy.ready_s2 = sy_ff.ready_s1;
      nxt_sy.lock_s1  = lk_ff.dll_done;
      nxt_sy.lock_s2  = sy_ff.lock_s1;
   end

   // System registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sy_ff <= '0;
      end else begin
         sy_ff <= nxt_sy;
      end
   end

   // Outputs straight from flops
   assign dq_oe_o      = lk_ff.dq_oe;
   assign dqs_oe_o     = lk_ff.dqs_oe;
   assign rd_o         = lk_ff.rd;
   assign mode_o       = lk_ff.mode;
   assign ready_o      = sy_ff.ready_s2;
   assign dll_locked_o = sy_ff.lock_s2;

endmodule

// >>> test/dsm_core_sva.sv
`timescale 1ns/1ps
module dsm_core_sva
   import dsm_pkg::*;
(
   // Clocks and reset
   input wire logic              mclk_i,
   input wire logic              rst_i,
   input wire logic              ck_i,
   // Link inputs
   input wire dsm_cmd_t          cmd_i,
   input wire dsm_ddr_t          wr_i,
   input wire logic [LANES-1:0]  dm_rise_i,
   input wire logic [LANES-1:0]  dm_fall_i,
   // Design outputs
   input wire logic              dq_oe_o,
   input wire logic              dqs_oe_o,
   input wire dsm_ddr_t          rd_o,
   input wire logic [ADDR_W-1:0] mode_o,
   input wire logic              ready_o,
   input wire logic              dll_locked_o
);
   // Command decode, only selected commands with clock enable count
   logic taken;
   logic rd_cmd;
   logic mr_load;
   assign taken   = cmd_i.cke & ~cmd_i.cs_n;
   assign rd_cmd  = taken & ({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n} == CMD_RD);
   assign mr_load = taken & ({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n} == CMD_MRS)
                    & (cmd_i.ba == BA_MR);

   property p_oe_pair;
      @(posedge ck_i) disable iff (rst_i) dq_oe_o |-> dqs_oe_o;
   endproperty
   a_oe_pair: assert property (p_oe_pair)
      else $error("read data driven without its strobe");
   property p_strobe;
      @(posedge ck_i) disable iff (rst_i)
         dq_oe_o |-> rd_o.dqs_rise == {LANES{1'b1}} && rd_o.dqs_fall == {LANES{1'b0}};
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("read strobe not on data edges");
   property p_idle;
      @(posedge ck_i) disable iff (rst_i) !dqs_oe_o |-> rd_o == '0;
   endproperty
   a_idle: assert property (p_idle)
      else $error("read lines not quiet while undriven");
   // Two edges of low clock enable leave no room for a late switch-off
   property p_cke;
      @(posedge ck_i) disable iff (rst_i)
         !cmd_i.cke ##1 !cmd_i.cke |=> !dq_oe_o && !dqs_oe_o;
   endproperty
   a_cke: assert property (p_cke)
      else $error("outputs driven with clock enable low");
   property p_rd_lat;
      @(posedge ck_i) disable iff (rst_i) $rose(dq_oe_o) |-> $past(rd_cmd, 3);
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read data without a read two clocks earlier");
   property p_mr_load;
      @(posedge ck_i) disable iff (rst_i) mr_load |=> mode_o == $past(cmd_i.addr);
   endproperty
   a_mr_load: assert property (p_mr_load)
      else $error("mode word differs from loaded address");
   // Without a load only the DLL reset bit may change, and only to zero
   property p_mode_hold;
      @(posedge ck_i) disable iff (rst_i) !mr_load |=> mode_o == ($past(mode_o) & 13'h1eff);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode word changed without a load");
   property p_dll_bit;
      @(posedge ck_i) disable iff (rst_i) $rose(mode_o[MR_DLL_RST_BIT]) && !mr_load
         |=> !mode_o[MR_DLL_RST_BIT];
   endproperty
   a_dll_bit: assert property (p_dll_bit)
      else $error("DLL reset bit did not clear itself");
   property p_dll_drop;
      @(posedge mclk_i) disable iff (rst_i) mode_o[MR_DLL_RST_BIT] |-> ##[1:40] !dll_locked_o;
   endproperty
   a_dll_drop: assert property (p_dll_drop)
      else $error("lock kept through a DLL reset");

   c_read: cover property (@(posedge ck_i) disable iff (rst_i) $rose(dq_oe_o));
   c_dll: cover property (@(posedge ck_i) disable iff (rst_i) mode_o[MR_DLL_RST_BIT]);
   c_ready: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(ready_o));
endmodule

bind dsm_core dsm_core_sva u_sva (.mclk_i(mclk_i), .rst_i(rst_i), .ck_i(ck_i),
   .cmd_i(cmd_i), .wr_i(wr_i), .dm_rise_i(dm_rise_i), .dm_fall_i(dm_fall_i),
   .dq_oe_o(dq_oe_o), .dqs_oe_o(dqs_oe_o), .rd_o(rd_o), .mode_o(mode_o),
   .ready_o(ready_o), .dll_locked_o(dll_locked_o));

// >>> test/dsm_ctl_model.sv
`timescale 1ns/1ps
module dsm_ctl_model
   import dsm_pkg::*;
(
   // Link clock from the bench
   input  wire logic             ck_i,
   // Command and write data toward the device
   output dsm_cmd_t              cmd_o,
   output dsm_ddr_t              wr_o,
   output logic [LANES-1:0]      dm_rise_o,
   output logic [LANES-1:0]      dm_fall_o
);
   // Power-up: clock enable low, deselected, every lane masked
   initial begin
      cmd_o     = {1'b0, 1'b1, 3'h7, {BA_W{1'b0}}, {ADDR_W{1'b0}}};
      wr_o      = '0;
      dm_rise_o = '1;
      dm_fall_o = '1;
   end
   // Step just past the command edge so the device samples settled pins
   task automatic tick();
      @(posedge ck_i);
      #1;
   endtask
   // One command held across exactly one rising edge
   task automatic cmd(input logic [2:0] op, input logic [BA_W-1:0] ba,
                      input logic [ADDR_W-1:0] a);
      cmd_o = {1'b1, 1'b0, op, ba, a};
      tick();
   endtask
   task automatic nop(input int n);
      repeat (n) cmd(3'h7, '0, '0);
   endtask
   // Any pin pattern for one edge, e.g. deselected or clock enable low
   task automatic raw(input dsm_cmd_t c);
      cmd_o = c;
      tick();
   endtask
   // One data pair with strobe edges inside each half; command is a nop meanwhile
   task automatic wpair(input logic [DQ_W-1:0] d0, input logic [DQ_W-1:0] d1,
                        input logic [LANES-1:0] m0, input logic [LANES-1:0] m1,
                        input logic [LANES-1:0] s0, input logic [LANES-1:0] s1);
      cmd_o     = {1'b1, 1'b0, 3'h7, {BA_W{1'b0}}, {ADDR_W{1'b0}}};
      wr_o      = {d0, d1, s0, s1};
      dm_rise_o = m0;
      dm_fall_o = m1;
      tick();
   endtask
   // Released lines: inverted data and no strobe edges, so stale values never match
   task automatic wdone();
      wr_o = {~wr_o.dq_rise, ~wr_o.dq_fall, {LANES{1'b0}}, {LANES{1'b1}}};
   endtask
endmodule

// >>> test/test_ddr_sdram_init_mode_access.sv
`timescale 1ns/1ps
module test_ddr_sdram_init_mode_access import dsm_pkg::*;;
   localparam int RFC_NOPS = 8; // Refresh recovery, chosen value
   logic mclk_i, rst_i, ck_i;
   dsm_cmd_t cmd;
   dsm_ddr_t wr, rd_o;
   logic [LANES-1:0] dm_rise, dm_fall;
   logic dq_oe_o, dqs_oe_o, ready_o, dll_locked_o;
   logic [ADDR_W-1:0] mode_o, mw;
   logic [DQ_W-1:0] mem [MEM_WORDS]; // Expected array contents
   int error_cnt, n_tests;

   dsm_core dut (.mclk_i(mclk_i), .rst_i(rst_i), .ck_i(ck_i), .cmd_i(cmd), .wr_i(wr),
      .dm_rise_i(dm_rise), .dm_fall_i(dm_fall), .dq_oe_o(dq_oe_o), .dqs_oe_o(dqs_oe_o),
      .rd_o(rd_o), .mode_o(mode_o), .ready_o(ready_o), .dll_locked_o(dll_locked_o));
   dsm_ctl_model u_ctl (.ck_i(ck_i), .cmd_o(cmd), .wr_o(wr), .dm_rise_o(dm_rise),
      .dm_fall_o(dm_fall));

   // Clocks: link rising edges coincide with system falling edges
   always #5 mclk_i = ~mclk_i;
   always #80 ck_i = ~ck_i;

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [ADDR_W-1:0] mword(input logic [2:0] bl, input logic bt,
                                               input logic [2:0] cl);
      mword = {OP_NORMAL, cl, bt, bl};
   endfunction
   // Column of burst word j, wrapping inside its block
   function automatic logic [2:0] bcol(input logic [2:0] s, input int j, input int bl,
                                       input logic il);
      logic [2:0] w;
      w = 3'(bl - 1);
      bcol = il ? (s ^ 3'(j)) : ((s & ~w) | ((s + 3'(j)) & w));
   endfunction

   // Write burst with auto precharge, random data and masks
   task automatic wr_burst(input logic [BA_W-1:0] b, input logic [1:0] r,
                           input logic [9:0] c, input logic [ADDR_W-1:0] m);
      logic [DQ_W-1:0]  d [2];
      logic [LANES-1:0] k [2];
      logic [LANES-1:0] q [2];
      int               bl;
      logic [6:0]       ix;
      bl = 2 << (m[2:0] - 1);
      u_ctl.cmd(CMD_WR, b, {2'h0, 1'b1, c});
      for (int p = 0; p < bl / 2; p++) begin
         for (int h = 0; h < 2; h++) begin
            d[h] = DQ_W'($urandom);
            k[h] = LANES'($urandom);
            // Strobe edge present in most lanes; a lane without one keeps its byte
            q[h] = ~(LANES'($urandom) & LANES'($urandom));
            ix = {b, r, bcol(c[2:0], 2 * p + h, bl, m[MR_BT_BIT])};
            for (int l = 0; l < LANES; l++)
               if (!k[h][l] && q[h][l]) mem[ix][8*l +: 8] = d[h][8*l +: 8];
         end
         u_ctl.wpair(d[0], d[1], k[0], k[1], q[0], ~q[1]);
      end
      u_ctl.wdone();
   endtask
   // Read burst; half-words are collected then lined up by the latency
   task automatic rd_burst(input logic [BA_W-1:0] b, input logic [1:0] r,
                           input logic [9:0] c, input logic [ADDR_W-1:0] m, input logic ap);
      logic [DQ_W-1:0] h [10];
      int              bl;
      int              off;
      bl  = 2 << (m[2:0] - 1);
      off = (m[6:4] == CL_2P5) ? 1 : 0;
      u_ctl.cmd(CMD_RD, b, {2'h0, ap, c});
      u_ctl.nop(2);
      for (int k = 0; k <= bl / 2; k++) begin
         h[2 * k]     = rd_o.dq_rise;
         h[2 * k + 1] = rd_o.dq_fall;
         if (k < bl / 2) chk("read_oe", dq_oe_o, 1);
         u_ctl.nop(1);
      end
      for (int j = 0; j < bl; j++)
         chk("read_data", h[j + off], mem[{b, r, bcol(c[2:0], j, bl, m[MR_BT_BIT])}]);
   endtask

   // Hang guard
   initial begin
      #900000;
      error_cnt++;
      final_report();
   end

   initial begin
      logic [BA_W-1:0] b;
      logic [ADDR_W-1:0] r;
      logic [9:0] c;
      error_cnt = 0;
      n_tests = 0;
      mclk_i = 0;
      ck_i = 0;
      rst_i = 1;
      foreach (mem[i]) mem[i] = '0;
      void'($urandom(31207));
      repeat (2) @(posedge ck_i);
      #1 rst_i = 0;
      // Power-up sequence, outputs must stay released meanwhile
      repeat (1250) u_ctl.tick();
      chk("powerup_oe", {dq_oe_o, dqs_oe_o}, 0);
      u_ctl.nop(1);
      u_ctl.cmd(CMD_PRE, 2'h0, 13'h0400);
      u_ctl.cmd(CMD_MRS, BA_EMR, 13'h0000);
      mw = mword(BL_4, 1'b0, CL_2) | 13'h0100;
      u_ctl.cmd(CMD_MRS, BA_MR, mw);
      chk("mode_dll", mode_o, mw);
      u_ctl.nop(1);
      chk("mode_selfclear", mode_o, mw & 13'h1eff);
      u_ctl.cmd(CMD_PRE, 2'h0, 13'h0400);
      u_ctl.cmd(CMD_REF, 2'h0, 13'h0000);
      u_ctl.nop(RFC_NOPS);
      u_ctl.cmd(CMD_REF, 2'h0, 13'h0000);
      u_ctl.nop(RFC_NOPS);
      chk("early_ready", ready_o, 0);
      chk("early_lock", dll_locked_o, 0);
      u_ctl.cmd(CMD_MRS, BA_MR, mword(BL_4, 1'b0, CL_2));
      u_ctl.nop(200);
      chk("ready", ready_o, 1);
      chk("dll_locked", dll_locked_o, 1);
      // Every length, order and latency; mode reload between write and read
      for (int i = 0; i < 12; i++) begin
         b = BA_W'($urandom);
         r = ADDR_W'($urandom);
         c = 10'($urandom);
         mw = mword(3'(1 + $urandom % 3), 1'($urandom), CL_2);
         u_ctl.cmd(CMD_MRS, BA_MR, mw);
         u_ctl.nop(2);
         u_ctl.cmd(CMD_ACT, b, r);
         u_ctl.nop(1);
         wr_burst(b, r[1:0], c, mw);
         u_ctl.nop(2);
         mw = mword(3'(1 + i % 3), 1'(i / 3 % 2), (i / 6 % 2 == 1) ? CL_2P5 : CL_2);
         u_ctl.cmd(CMD_MRS, BA_MR, mw);
         chk("mode_fields", mode_o, mw);
         u_ctl.nop(2);
         u_ctl.cmd(CMD_ACT, b, r);
         u_ctl.nop(1);
         rd_burst(b, r[1:0], c, mw, 1'b1);
      end
      // Two banks open; auto precharge closes only the one read
      u_ctl.cmd(CMD_ACT, 2'h0, 13'h0001);
      u_ctl.cmd(CMD_ACT, 2'h3, 13'h0002);
      rd_burst(2'h0, 2'h1, 10'h005, mw, 1'b1);
      rd_burst(2'h3, 2'h2, 10'h003, mw, 1'b0);
      // Read to open bank 3, clock enable low until that burst is spent
      u_ctl.cmd(CMD_RD, 2'h3, 13'h0003);
      repeat (6) begin
         u_ctl.raw({1'b0, 1'b0, 3'h7, 2'h0, 13'h0000});
         chk("cke_low_oe", {dq_oe_o, dqs_oe_o}, 0);
      end
      // Deselected read to the open bank, then a read to the closed one
      u_ctl.raw({1'b1, 1'b1, CMD_RD, 2'h3, 13'h0003});
      u_ctl.cmd(CMD_RD, 2'h0, 13'h0005);
      repeat (4) begin
         u_ctl.nop(1);
         chk("closed_bank_oe", dq_oe_o, 0);
      end
      final_report();
   end
endmodule
